// *** csr_host.sv ***
// Host model on the register port
`timescale 1ns/10ps
module csr_host (
    // Clock and read data
    input wire logic clk,
    input wire logic [7:0] rd_data,
    // Strobes, offset and write data
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data
);
    initial {wr_en, rd_en, addr, wr_data} = '0;
    // One write strobe; released lines flip so stale values never pass
    task automatic wr(input logic [7:0] a, dv);
        @(posedge clk) {wr_en, addr, wr_data} <= {1'b1, a, dv};
        @(posedge clk) {wr_en, addr, wr_data} <= {1'b0, ~a, ~dv};
        @(negedge clk);
    endtask
    // Read strobe; data taken once the answering edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] dv);
        @(posedge clk) {rd_en, addr} <= {1'b1, a};
        @(posedge clk) {rd_en, addr} <= {1'b0, ~a};
        @(negedge clk) dv = rd_data;
    endtask
endmodule

// *** csr_pkg.sv ***
// Constants for the charge setpoint register bank
package csr_pkg;
    // Register offsets on the internal register port
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    localparam logic [7:0] ADDR_PRE_TERM = 8'h05;
    localparam logic [7:0] ADDR_VOLTAGE = 8'h06;
    // Reset values
    localparam logic [7:0] RST_CURRENT = 8'h20;
    localparam logic [7:0] RST_PRE_TERM = 8'h13;
    localparam logic [7:0] RST_VOLTAGE = 8'h5e;
    // Field positions
    localparam int PULSE_EN_BIT = 7;
    localparam int FCC_MSB = 6;
    localparam int IPRE_MSB = 7;
    localparam int IPRE_LSB = 4;
    localparam int TERM_MSB = 3;
    localparam int VCHG_MSB = 7;
    localparam int VCHG_LSB = 2;
    localparam int ENTRY_BIT = 1;
    localparam int RECHG_BIT = 0;
    // Clamp limits
    localparam logic [6:0] FCC_MAX = 7'h2f;
    localparam logic [5:0] VCHG_MAX = 6'h30;
endpackage

// *** csr_regs.sv ***
// Charge setpoint register bank: three byte registers with decoded setpoints
// Functional notes
// - Bit 7 of current register enables pulsing
// - Fast-charge current field bits 6:0, 64mA steps
// - Zero fast-charge code disables charging
// - Current codes above 0101111 clamp there
// - Precharge current field bits 7:4, resets 0001
// - Termination current field bits 3:0, resets 0011
// - Charge voltage field bits 7:2, resets 010111
// - Voltage codes above 110000 clamp there
// - Bit 1 selects fast-charge entry threshold
// - Bit 0 selects recharge offset below setpoint
// - Pulse requests settable only while enabled
`timescale 1ns/10ps
module csr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Soft restore events
    input wire logic reg_reset_cmd,
    input wire logic watchdog_expired,
    // Pulse request writes and sequence end
    input wire logic pulse_raise_wr,
    input wire logic pulse_lower_wr,
    input wire logic pulse_done,
    output logic pulse_raise_request,
    output logic pulse_lower_request,
    // Decoded setpoints
    output logic pulse_signal_enable,
    output logic [6:0] fast_charge_current_setpoint,
    output logic charge_disable,
    output logic [3:0] precharge_current_setpoint,
    output logic [3:0] termination_current_setpoint,
    output logic [5:0] charge_voltage_setpoint,
    output logic fast_charge_entry_threshold,
    output logic recharge_offset_select
);
    // Register images as the host sees them
    logic [7:0] cur_word;
    logic [7:0] pre_word;
    logic [7:0] volt_word;
    // Stored fields, one flop group per field
    logic en_r;
    logic [6:0] fcc_r;
    logic [3:0] pre_code_r;
    logic [3:0] term_r;
    logic [5:0] volt_code_r;
    logic entry_r;
    logic rechg_r;
    // Restore request and write decodes
    logic restore;
    logic hit_cur;
    logic hit_pre;
    logic hit_volt;
    // Clamped codes from the saturators
    logic [6:0] fcc_clamped;
    logic [5:0] vchg_clamped;
    // Pulse request set terms
    logic raise_set;
    logic lower_set;
    // Read mux result ahead of the read data register
    logic [7:0] rd_nxt;

    // Either soft event returns every field to default
    assign restore = reg_reset_cmd | watchdog_expired;

    // Write decodes; a restore in the same cycle overrides them
    assign hit_cur = wr_en && (addr == csr_pkg::ADDR_CURRENT);
    assign hit_pre = wr_en && (addr == csr_pkg::ADDR_PRE_TERM);
    assign hit_volt = wr_en && (addr == csr_pkg::ADDR_VOLTAGE);

    // Pulse enable bit of the current register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_r <= csr_pkg::RST_CURRENT[csr_pkg::PULSE_EN_BIT];
        end else if (restore) begin
            en_r <= csr_pkg::RST_CURRENT[csr_pkg::PULSE_EN_BIT];
        end else if (hit_cur) begin
            en_r <= wr_data[csr_pkg::PULSE_EN_BIT];
        end
    end

    // Fast-charge code, stored raw so reads show what was written
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fcc_r <= csr_pkg::RST_CURRENT[csr_pkg::FCC_MSB:0];
        end else if (restore) begin
            fcc_r <= csr_pkg::RST_CURRENT[csr_pkg::FCC_MSB:0];
        end else if (hit_cur) begin
            fcc_r <= wr_data[csr_pkg::FCC_MSB:0];
        end
    end

    // Precharge current code
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_code_r <= csr_pkg::RST_PRE_TERM[csr_pkg::IPRE_MSB:csr_pkg::IPRE_LSB];
        end else if (restore) begin
            pre_code_r <= csr_pkg::RST_PRE_TERM[csr_pkg::IPRE_MSB:csr_pkg::IPRE_LSB];
        end else if (hit_pre) begin
            pre_code_r <= wr_data[csr_pkg::IPRE_MSB:csr_pkg::IPRE_LSB];
        end
    end

    // Termination current code
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            term_r <= csr_pkg::RST_PRE_TERM[csr_pkg::TERM_MSB:0];
        end else if (restore) begin
            term_r <= csr_pkg::RST_PRE_TERM[csr_pkg::TERM_MSB:0];
        end else if (hit_pre) begin
            term_r <= wr_data[csr_pkg::TERM_MSB:0];
        end
    end

    // Charge voltage code, stored raw
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            volt_code_r <= csr_pkg::RST_VOLTAGE[csr_pkg::VCHG_MSB:csr_pkg::VCHG_LSB];
        end else if (restore) begin
            volt_code_r <= csr_pkg::RST_VOLTAGE[csr_pkg::VCHG_MSB:csr_pkg::VCHG_LSB];
        end else if (hit_volt) begin
            volt_code_r <= wr_data[csr_pkg::VCHG_MSB:csr_pkg::VCHG_LSB];
        end
    end

    // Precharge to fast-charge threshold select
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            entry_r <= csr_pkg::RST_VOLTAGE[csr_pkg::ENTRY_BIT];
        end else if (restore) begin
            entry_r <= csr_pkg::RST_VOLTAGE[csr_pkg::ENTRY_BIT];
        end else if (hit_volt) begin
            entry_r <= wr_data[csr_pkg::ENTRY_BIT];
        end
    end

    // Recharge offset select
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rechg_r <= csr_pkg::RST_VOLTAGE[csr_pkg::RECHG_BIT];
        end else if (restore) begin
            rechg_r <= csr_pkg::RST_VOLTAGE[csr_pkg::RECHG_BIT];
        end else if (hit_volt) begin
            rechg_r <= wr_data[csr_pkg::RECHG_BIT];
        end
    end

    // Register images rebuilt from the fields
    assign cur_word = {en_r, fcc_r};
    assign pre_word = {pre_code_r, term_r};
    assign volt_word = {volt_code_r, entry_r, rechg_r};

    // Pulse writes only count while the enable bit is set
    assign raise_set = pulse_raise_wr && en_r;
    assign lower_set = pulse_lower_wr && en_r;

    // Raise request: set beats sequence end in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_raise_request <= 1'b0;
        end else if (restore) begin
            pulse_raise_request <= 1'b0;
        end else if (raise_set) begin
            pulse_raise_request <= 1'b1;
        end else if (pulse_done) begin
            pulse_raise_request <= 1'b0;
        end
    end

    // Lower request: same policy as the raise request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_lower_request <= 1'b0;
        end else if (restore) begin
            pulse_lower_request <= 1'b0;
        end else if (lower_set) begin
            pulse_lower_request <= 1'b1;
        end else if (pulse_done) begin
            pulse_lower_request <= 1'b0;
        end
    end

    // Clamp over-range codes; the stored bits stay as written
    csr_sat #(.W(7)) u_fcc_sat (
        .code(fcc_r),
        .limit(csr_pkg::FCC_MAX),
        .clamped(fcc_clamped)
    );
    csr_sat #(.W(6)) u_vchg_sat (
        .code(volt_code_r),
        .limit(csr_pkg::VCHG_MAX),
        .clamped(vchg_clamped)
    );

    // Decoded setpoints
    assign pulse_signal_enable = en_r;
    assign fast_charge_current_setpoint = fcc_clamped;
    assign charge_disable = (fcc_r == 7'h00);
    assign precharge_current_setpoint = pre_code_r;
    assign termination_current_setpoint = term_r;
    assign charge_voltage_setpoint = vchg_clamped;
    assign fast_charge_entry_threshold = entry_r;
    assign recharge_offset_select = rechg_r;

    // Read mux; unmapped offsets return zero
    always_comb begin
        rd_nxt = 8'h00;
        case (addr)
            csr_pkg::ADDR_CURRENT: rd_nxt = cur_word;
            csr_pkg::ADDR_PRE_TERM: rd_nxt = pre_word;
            csr_pkg::ADDR_VOLTAGE: rd_nxt = volt_word;
            default: rd_nxt = 8'h00;
        endcase
    end

    // Read data register holds until the next read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= rd_nxt;
        end
    end
endmodule

// *** csr_regs_test.sv ***
// Self-checking bench for the charge setpoint bank
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module csr_regs_test;
    logic clk = 0, reset = 1, wr_en, rd_en, charge_disable, pulse_raise_request;
    logic pulse_lower_request, pulse_signal_enable, fast_charge_entry_threshold;
    logic recharge_offset_select;
    logic [7:0] addr, wr_data, rd_data, d;
    logic [6:0] fast_charge_current_setpoint;
    logic [5:0] charge_voltage_setpoint;
    logic [3:0] precharge_current_setpoint, termination_current_setpoint;
    logic [4:0] ev = '0;
    int n_errors = 0, total_checks = 0;
    // Event inputs: restore, watchdog, raise, lower, done
    wire reg_reset_cmd = ev[4], watchdog_expired = ev[3], pulse_raise_wr = ev[2];
    wire pulse_lower_wr = ev[1], pulse_done = ev[0];
    always #50 clk = ~clk;
    csr_host csr_host_i (.*);
    csr_regs csr_regs_i (.*);
    task automatic fire(input logic [4:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= '0;
        @(negedge clk);
    endtask
    task automatic t_reset;
        logic [7:0] rv [3] = '{8'h20, 8'h13, 8'h5e};
        foreach (rv[i]) begin
            csr_host_i.rd(8'h04 + 8'(i), d); `CHK("rst", rv[i], d)
        end
        csr_host_i.rd(8'h07, d); `CHK("unmapped", 8'h00, d)
        csr_host_i.wr(8'h05, 8'hf0);
        `CHK("pt", 8'hf0, {precharge_current_setpoint, termination_current_setpoint})
        $display("t_reset done");
    endtask
    task automatic t_cur;
        logic [7:0] cw [4] = '{8'h00, 8'h2f, 8'hb0, 8'hff};
        foreach (cw[i]) begin
            csr_host_i.wr(8'h04, cw[i]);
            `CHK("fcc", cw[i][6:0] > 7'h2f ? 7'h2f : cw[i][6:0], fast_charge_current_setpoint)
            `CHK("dis", cw[i][6:0] == 7'h00, charge_disable)
            `CHK("en", cw[i][7], pulse_signal_enable)
            csr_host_i.rd(8'h04, d); `CHK("raw", cw[i], d)
        end
        $display("t_cur done");
    endtask
    task automatic t_volt;
        logic [7:0] vw [3] = '{8'hc3, 8'hfc, 8'h56};
        foreach (vw[i]) begin
            csr_host_i.wr(8'h06, vw[i]);
            `CHK("v", vw[i][7:2] > 6'h30 ? 6'h30 : vw[i][7:2], charge_voltage_setpoint)
            `CHK("b", vw[i][1:0], {fast_charge_entry_threshold, recharge_offset_select})
        end
        $display("t_volt done");
    endtask
    task automatic t_pulse;
        csr_host_i.wr(8'h04, 8'h00); fire(5'b00110);
        `CHK("off", 2'b00, {pulse_raise_request, pulse_lower_request})
        csr_host_i.wr(8'h04, 8'h80); fire(5'b00110);
        `CHK("on", 2'b11, {pulse_raise_request, pulse_lower_request})
        fire(5'b00001); `CHK("done", 2'b00, {pulse_raise_request, pulse_lower_request})
        $display("t_pulse done");
    endtask
    task automatic t_restore;
        csr_host_i.wr(8'h04, 8'hff); fire(5'b10000);
        csr_host_i.rd(8'h04, d); `CHK("cmd", 8'h20, d)
        csr_host_i.wr(8'h06, 8'h00); fire(5'b01000);
        csr_host_i.rd(8'h06, d); `CHK("wdog", 8'h5e, d)
        $display("t_restore done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset <= 0;
        t_reset(); t_cur(); t_volt(); t_pulse(); t_restore(); summarize();
    end
endmodule

// *** csr_sat.sv ***
// Saturating clamp of a setpoint code to a maximum
`timescale 1ns/10ps
module csr_sat #(
    parameter int W = 8
) (
    // Code in and limit
    input wire logic [W-1:0] code,
    input wire logic [W-1:0] limit,
    // Clamped code
    output logic [W-1:0] clamped
);
    // Codes above the limit take the limit
    assign clamped = (code > limit) ? limit : code;
endmodule

// *** csr_sva.sv ***
// Checker for the charge setpoint bank
`timescale 1ns/10ps
module csr_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port and events
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic reg_reset_cmd,
    input wire logic watchdog_expired,
    input wire logic pulse_raise_wr,
    // Outputs watched
    input wire logic pulse_raise_request,
    input wire logic pulse_signal_enable,
    input wire logic charge_disable,
    input wire logic fast_charge_entry_threshold,
    input wire logic recharge_offset_select,
    input wire logic [6:0] fast_charge_current_setpoint,
    input wire logic [5:0] charge_voltage_setpoint
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Writes taken with no restore pending
    wire w = wr_en & ~reg_reset_cmd & ~watchdog_expired;
    wire w4 = w && addr == 8'h04;
    wire w6 = w && addr == 8'h06;
    property p_en; w4 |=> pulse_signal_enable == $past(wr_data[7]); endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_ic; w4 && wr_data[6:0] < 7'h30
        |=> fast_charge_current_setpoint == $past(wr_data[6:0]); endproperty
    a_ic: assert property (p_ic) else $error("current");
    property p_cl; w4 && wr_data[6:0] > 7'h2f |=> fast_charge_current_setpoint == 7'h2f; endproperty
    a_cl: assert property (p_cl) else $error("clamp");
    property p_dis; charge_disable == (fast_charge_current_setpoint == 7'h00); endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_v; w6 |=> charge_voltage_setpoint ==
        ($past(wr_data[7:2]) > 6'h30 ? 6'h30 : $past(wr_data[7:2])); endproperty
    a_v: assert property (p_v) else $error("voltage");
    property p_b; w6 |=> {fast_charge_entry_threshold, recharge_offset_select}
        == $past(wr_data[1:0]); endproperty
    a_b: assert property (p_b) else $error("thresholds");
    property p_rs; reg_reset_cmd || watchdog_expired |=> fast_charge_current_setpoint == 7'h20
        && charge_voltage_setpoint == 6'h17 && !pulse_signal_enable; endproperty
    a_rs: assert property (p_rs) else $error("restore");
    property p_pu; pulse_raise_wr && !pulse_signal_enable && !pulse_raise_request
        |=> !pulse_raise_request; endproperty
    a_pu: assert property (p_pu) else $error("pulse");
endmodule
bind csr_regs csr_sva csr_sva_i (.*);
